/* core/slot_map.sv */
// Receive slot mapper for secondary port channels six and seven
`timescale 1ns/10ps
`default_nettype none
module slot_map #(
  parameter int DATA_W = 32
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RST,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic [7:0]        REG_WDATA,
  output var  logic [7:0]        REG_RDATA,
  input  wire logic [1:0]        FRAME_FMT,
  input  wire logic              IN_VALID,
  input  wire logic              IN_RIGHT,
  input  wire logic [4:0]        IN_SLOT,
  input  wire logic [DATA_W-1:0] IN_DATA,
  output var  logic              IN_READY,
  output var  logic              OUT_VALID,
  output var  logic [1:0]        OUT_CHAN,
  output var  logic [1:0]        OUT_DEST,
  output var  logic [DATA_W-1:0] OUT_DATA,
  input  wire logic              OUT_READY
);
  // Per channel configuration: [0] is channel six, [1] channel seven
  logic [7:0] cfg [slot_map_pkg::NUM_CH];
  logic [7:0] next_cfg [slot_map_pkg::NUM_CH];
  logic [7:0] reg_rdata;
  logic [7:0] next_rdata;
  logic [slot_map_pkg::NUM_CH-1:0] hit;

  // Register writes; the reserved bit is never stored so it reads zero
  always_comb begin
    next_cfg = cfg;
    if (REG_WR && REG_ADDR == slot_map_pkg::CH6_OFFSET) begin
      next_cfg[0] = {1'b0, REG_WDATA[slot_map_pkg::RSVD_BIT-1:0]};
    end
    if (REG_WR && REG_ADDR == slot_map_pkg::CH7_OFFSET) begin
      next_cfg[1] = {1'b0, REG_WDATA[slot_map_pkg::RSVD_BIT-1:0]};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfg[0] <= slot_map_pkg::CH6_RESET;
      cfg[1] <= slot_map_pkg::CH7_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_comb begin
    next_rdata = reg_rdata;
    if (REG_RD) begin
      unique case (REG_ADDR)
        slot_map_pkg::CH6_OFFSET: next_rdata = cfg[0];
        slot_map_pkg::CH7_OFFSET: next_rdata = cfg[1];
        default:                  next_rdata = slot_map_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      reg_rdata <= slot_map_pkg::READ_UNMAPPED;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
  assign REG_RDATA = reg_rdata;

  // Slot match per channel: TDM uses all five bits, I2S/LJ splits halves
  generate
    for (genvar c = 0; c < slot_map_pkg::NUM_CH; c++) begin : g_match
      logic [4:0] sel;
      logic       src_on;
      assign sel    = cfg[c][slot_map_pkg::SLOT_HI:slot_map_pkg::SLOT_LO];
      assign src_on = cfg[c][slot_map_pkg::SRC_HI:slot_map_pkg::SRC_LO]
                      != slot_map_pkg::SRC_OFF;
      always_comb begin
        if (FRAME_FMT == slot_map_pkg::FMT_TDM) begin
          hit[c] = src_on && (IN_SLOT == sel);
        end else begin
          // Upper selector bit names the right half, low four the slot
          hit[c] = src_on && (IN_RIGHT == sel[slot_map_pkg::HALF_BIT])
                   && (IN_SLOT[slot_map_pkg::HALF_BIT-1:0]
                       == sel[slot_map_pkg::HALF_BIT-1:0]);
        end
      end
    end
  endgenerate

  // Two-entry skid buffer so a stalled receiver loses no word
  logic [DATA_W+3:0] buf_mem [2];
  logic [DATA_W+3:0] next_mem [2];
  logic              wr_ptr, rd_ptr, next_wr, next_rd;
  logic [1:0]        count, next_count;
  logic              push, pop;
  logic [DATA_W+3:0] word;
  logic              take;

  // Channel six wins if both selectors point at the same slot
  always_comb begin
    take = 1'b0;
    word = '0;
    if (hit[0]) begin
      take = 1'b1;
      // Destination code carries playback, loopback ADC2 or chain device one
      word = {slot_map_pkg::CHAN_SIX,
              cfg[0][slot_map_pkg::SRC_HI:slot_map_pkg::SRC_LO], IN_DATA};
    end else if (hit[1]) begin
      take = 1'b1;
      // Same codes for channel seven: ADC3 loopback or chain device two
      word = {slot_map_pkg::CHAN_SEVEN,
              cfg[1][slot_map_pkg::SRC_HI:slot_map_pkg::SRC_LO], IN_DATA};
    end
  end

  assign push = IN_VALID && IN_READY && take;
  assign pop  = OUT_VALID && OUT_READY;

  always_comb begin
    next_mem   = buf_mem;
    next_wr    = wr_ptr;
    next_rd    = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = word;
      next_wr          = ~wr_ptr;
    end
    if (pop) begin
      next_rd = ~rd_ptr;
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
    end else begin
      buf_mem <= next_mem;
      wr_ptr  <= next_wr;
      rd_ptr  <= next_rd;
      count   <= next_count;
    end
  end

  // Outputs registered from the buffer state; ready drops when full
  logic              out_valid_q, in_ready_q;
  logic [DATA_W+3:0] out_word_q;
  logic              next_out_valid, next_in_ready;
  logic [DATA_W+3:0] next_out_word;

  // Flags look at the next fill level so they never lag the buffer
  always_comb begin
    next_out_valid = next_count != slot_map_pkg::BUF_EMPTY;
    next_in_ready  = next_count != slot_map_pkg::BUF_FULL;
    next_out_word  = next_mem[next_rd];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      out_valid_q <= 1'b0;
      in_ready_q  <= 1'b0;
      out_word_q  <= '0;
    end else begin
      out_valid_q <= next_out_valid;
      in_ready_q  <= next_in_ready;
      out_word_q  <= next_out_word;
    end
  end
  assign OUT_VALID = out_valid_q;
  assign IN_READY  = in_ready_q;
  assign OUT_CHAN  = out_word_q[DATA_W+3:DATA_W+2];
  assign OUT_DEST  = out_word_q[DATA_W+1:DATA_W];
  assign OUT_DATA  = out_word_q[DATA_W-1:0];
endmodule
`default_nettype wire

/* core/slot_map_pkg.sv */
// Package: register map, field layout and codes of the receive slot mapper
package slot_map_pkg;
  localparam logic [7:0] CH6_OFFSET   = 8'h2d;
  localparam logic [7:0] CH7_OFFSET   = 8'h2e;
  localparam logic [7:0] CH6_RESET    = 8'h05;
  localparam logic [7:0] CH7_RESET    = 8'h06;
  localparam int         SRC_HI       = 6;
  localparam int         SRC_LO       = 5;
  localparam int         SLOT_HI      = 4;
  localparam int         SLOT_LO      = 0;
  localparam int         RSVD_BIT     = 7;
  localparam int         SLOT_W       = 5;
  localparam int         HALF_BIT     = 4;
  localparam int         NUM_CH       = 2;
  localparam logic [1:0] SRC_OFF      = 2'h0;
  localparam logic [1:0] SRC_PLAY     = 2'h1;
  localparam logic [1:0] SRC_LOOP     = 2'h2;
  localparam logic [1:0] SRC_CHAIN    = 2'h3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Channel tags carried with each buffered word
  localparam logic [1:0] CHAN_SIX     = 2'h0;
  localparam logic [1:0] CHAN_SEVEN   = 2'h1;
  // Fill levels of the two-entry buffer
  localparam logic [1:0] BUF_EMPTY    = 2'h0;
  localparam logic [1:0] BUF_FULL     = 2'h2;
  // Framing modes of the serial port
  typedef enum logic [1:0] {
    FMT_TDM = 2'h0,
    FMT_I2S = 2'h1,
    FMT_LJ  = 2'h2
  } frame_type;
endpackage

/* dv/slot_map_chk.sv */
// Checker: port relations of the slot mapper
`timescale 1ns/10ps
`default_nettype none
module slot_map_chk (
  input wire logic       CLK_SYS, RST, REG_WR, REG_RD, OUT_VALID, OUT_READY, IN_READY,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input wire logic [1:0] OUT_CHAN, OUT_DEST
);
  // One clock domain; nothing is judged while reset is high
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  rsvd_zero_a: assert property (REG_RD |=> !REG_RDATA[7]) else $error("rsvd");
  rd_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("rd");
  dest_on_a: assert property (OUT_VALID |-> OUT_DEST != 2'h0) else $error("dest");
  chan_ok_a: assert property (OUT_VALID |-> !OUT_CHAN[1]) else $error("chan");
  valid_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID) else $error("v");
  // A refused input only makes sense while the buffer holds a word
  full_stall_a: assert property (!IN_READY && !$past(RST) |-> OUT_VALID) else $error("full");
  dest_hold_a: assert property (OUT_VALID && !OUT_READY |=> $stable(OUT_DEST))
    else $error("dh");
  chan_hold_a: assert property (OUT_VALID && !OUT_READY |=> $stable(OUT_CHAN))
    else $error("ch");
  six_echo_a: assert property (REG_WR && REG_ADDR == 8'h2d ##1 REG_RD && REG_ADDR == 8'h2d
    |=> REG_RDATA == {1'b0, $past(REG_WDATA[6:0], 2)}) else $error("echo");
endmodule
bind slot_map slot_map_chk mon (.CLK_SYS, .RST, .REG_WR, .REG_RD, .OUT_VALID, .OUT_READY, .IN_READY,
  .REG_ADDR, .REG_WDATA, .REG_RDATA, .OUT_CHAN, .OUT_DEST);
`default_nettype wire

/* dv/sink_model.sv */
// Sink model: accepts mapped words, stalling at random
`timescale 1ns/10ps
`default_nettype none
module sink_model (input wire logic clk, output var logic rdy);
  int seed = 32'h7ec2;
  // Ready moves after the edge; random stalls fill the buffer
  always @(posedge clk) #1 rdy = 1'($random(seed));
  initial rdy = 1'b0;
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Testbench: slot mapper against a queue model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, iv = 0, ir = 0, irdy, ov, ordy;
  logic [7:0] ad = 0, wd = 0, rq, c[2];
  logic [4:0] sl = 0, k;
  logic [1:0] fm = 0, ch, de;
  logic [31:0] id = 0, od;
  logic [35:0] q[$];
  int fails = 0, cmp_count = 0, cyc = 0, seed = 32'h7ec2;
  slot_map dut (.CLK_SYS(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(ad),
    .REG_WDATA(wd), .REG_RDATA(rq), .FRAME_FMT(fm), .IN_VALID(iv), .IN_RIGHT(ir),
    .IN_SLOT(sl), .IN_DATA(id), .IN_READY(irdy), .OUT_VALID(ov), .OUT_CHAN(ch),
    .OUT_DEST(de), .OUT_DATA(od), .OUT_READY(ordy));
  sink_model sink (.clk(clk), .rdy(ordy));
  initial forever #20 clk = ~clk;
  task chk(input string n, input logic [35:0] s, e);
    cmp_count++;
    if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
    fails += (s !== e);
  endtask
  task summarize;
    fails += (cyc >= 20000);
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Optional write, then a read straight after it
  task rw(input logic w, input logic [7:0] a, d, e);
    {wr, ad, wd} = {w, a, d};
    @(posedge clk) #1 {wr, rd} = 2'h1;
    @(posedge clk) #1 rd = 0;
    @(posedge clk) #1 chk("reg", rq, e);
  endtask
  // Word held until ready; channel six wins a double hit
  task send;
    k = $random(seed) & 3 ? c[$random(seed) & 1][4:0] : 5'($random(seed));
    id = $random(seed);
    {iv, ir, sl} = {1'b1, fm ? {k[4], 1'b0, k[3:0]} : {id[0], k}};
    while (irdy !== 1) @(posedge clk) #1;
    @(posedge clk) #1;
    if (c[0][6:5] && k == c[0][4:0]) q.push_back({2'h0, c[0][6:5], id});
    else if (c[1][6:5] && k == c[1][4:0]) q.push_back({2'h1, c[1][6:5], id});
  endtask
  // Each handshake must carry the oldest expected word
  always @(posedge clk) begin
    if (ov === 1 && ordy === 1)
      chk("word", {ch, de, od}, q.pop_front());
    if (++cyc == 20000)
      summarize();
  end
  initial begin
    #781 rst = 0;
    @(posedge clk) #1;
    rw(0, 8'h2d, 0, 8'h05);
    rw(0, 8'h2e, 0, 8'h06);
    rw(0, 8'h30, 0, 0);
    for (int r = 0; r < 12; r++) begin
      fm = 2'(r % 3);
      for (int j = 0; j < 2; j++) begin
        c[j] = {1'b0, 2'(r + j), 5'($random(seed))};
        rw(1, 8'h2d + 8'(j), c[j], {1'b0, c[j][6:0]});
      end
      repeat (20) send();
      iv = 0;
      while (q.size() != 0) @(posedge clk) #1;
    end
    summarize();
  end
endmodule
`default_nettype wire
